/* core/dgl_control.v */
`timescale 1ns/1ps
`include "dgl_defs.vh"

// Behaviour
// (RULE1) NV gain bits 9:8, others zero
// (RULE2) Supply reference forces unity gain
// (RULE3) Lock field: high code, low config
// (RULE4) Locks never gate nonvolatile writes
// (RULE5) Nonvolatile writes need programming voltage present
// (RULE6) Power-down bits always writable
// (RULE7) Lock register two bits per channel
// (RULE8) Code selects ladder tap, top leaves one
// (RULE9) Powered-down channel disconnects ladder reference
// (RULE10) Four reference sources per ladder
// (RULE11) Power/brownout reset loads reference select
// (RULE12) Supply mode disconnects external reference pin
// (RULE13) Host picks buffered or unbuffered explicitly
// (RULE14) Host uses supply code when pin tied
// (RULE15) Codes 00 supply, 01 bandgap, 10 unbuffered
// (RULE16) Power-down codes open, 100k, 1k, normal
// (RULE17) Code 11 selects buffered external pin
// (RULE18) Locked volatile write leaves value unchanged

module dgl_control #(
	parameter NUM_CHAN = 2,
	parameter RES_BITS = 12,
	parameter [1:0] FACTORY_VREF = `DGL_RST_VREF
) (
	input wire ref_clk,
	input wire reset,
	input wire high_voltage_program_pin,
	input wire power_brownout_reset,
	input wire wr_en,
	input wire [4:0] wr_addr,
	input wire [15:0] wr_data,
	input wire rd_en,
	input wire [4:0] rd_addr,
	output reg [15:0] rd_data,
	output reg rd_valid,
	output reg wr_done,
	output reg wr_refused,
	output wire [4*NUM_CHAN-1:0] ref_route,
	output wire [NUM_CHAN-1:0] ext_pin_connect,
	output wire [NUM_CHAN-1:0] gain_two,
	output wire [NUM_CHAN*RES_BITS-1:0] ladder_tap,
	output wire [NUM_CHAN*(RES_BITS+1)-1:0] elements_above_tap,
	output wire [NUM_CHAN-1:0] out_open,
	output wire [NUM_CHAN-1:0] out_load_100k,
	output wire [NUM_CHAN-1:0] out_load_1k
);

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	reg [2:0] hv_sync_reg;
	reg [2:0] bor_sync_reg;
	reg hv_level_reg;
	reg bor_level_reg;
	reg boot_load_reg;

	// Three stages; a level counts only once stages two and three agree
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hv_sync_reg <= 3'h0;
			bor_sync_reg <= 3'h0;
			hv_level_reg <= 1'b0;
			bor_level_reg <= 1'b0;
			boot_load_reg <= 1'b1;
		end else begin
			hv_sync_reg <= {hv_sync_reg[1:0], high_voltage_program_pin};
			bor_sync_reg <= {bor_sync_reg[1:0], power_brownout_reset};
			if (hv_sync_reg[1] == hv_sync_reg[2]) begin
				hv_level_reg <= hv_sync_reg[2];
			end
			if (bor_sync_reg[1] == bor_sync_reg[2]) begin
				bor_level_reg <= bor_sync_reg[2];
			end
			boot_load_reg <= 1'b0;
		end
	end

	// Load on the first cycle after release and on each rising brownout edge
	wire bor_rise = (bor_sync_reg[1] == bor_sync_reg[2]) & bor_sync_reg[2] & ~bor_level_reg;
	wire por_load = boot_load_reg | bor_rise; // RULE11

	// --------------------------------------------------------------
	// Write decode
	// --------------------------------------------------------------
	wire hv_ok = hv_level_reg; // RULE5
	wire is_nv = (wr_addr == `DGL_ADDR_NV_VREF) | (wr_addr == `DGL_ADDR_NV_GAIN) | (wr_addr == `DGL_ADDR_NV_LOCK);
	wire nv_wr = wr_en & is_nv & hv_ok; // RULE4 RULE5
	wire pd_wr = wr_en & (wr_addr == `DGL_ADDR_PD); // RULE6
	wire vref_wr = wr_en & (wr_addr == `DGL_ADDR_VREF);
	wire gain_wr = wr_en & (wr_addr == `DGL_ADDR_GAIN);

	wire [NUM_CHAN*RES_BITS-1:0] code_all;
	wire [2*NUM_CHAN-1:0] vref_all;
	wire [2*NUM_CHAN-1:0] pd_all;
	wire [NUM_CHAN-1:0] gain_all;
	wire [2*NUM_CHAN-1:0] nv_vref_all;
	wire [NUM_CHAN-1:0] nv_gain_all;
	wire [2*NUM_CHAN-1:0] nv_lock_all;
	wire [NUM_CHAN-1:0] code_hit;
	wire [NUM_CHAN-1:0] code_blocked;
	wire [NUM_CHAN-1:0] cfg_blocked;

	// --------------------------------------------------------------
	// Per-channel state
	// --------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < NUM_CHAN; c = c + 1) begin : chan_g
			reg [RES_BITS-1:0] code_reg;
			reg [1:0] vref_reg;
			reg [1:0] pd_reg;
			reg gain_reg;
			reg [1:0] nv_vref_reg;
			reg nv_gain_reg;
			reg [1:0] nv_lock_reg;

			wire code_lock = nv_lock_reg[`DGL_LOCK_CODE_BIT]; // RULE3
			wire cfg_lock = nv_lock_reg[`DGL_LOCK_CFG_BIT]; // RULE3
			wire [4:0] my_code_addr = (c == 0) ? `DGL_ADDR_CODE0 : `DGL_ADDR_CODE1;

			assign code_hit[c] = wr_en & (wr_addr == my_code_addr);
			assign code_blocked[c] = code_hit[c] & code_lock;
			assign cfg_blocked[c] = (vref_wr | gain_wr) & cfg_lock;

			always @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					code_reg <= {RES_BITS{1'b0}};
					vref_reg <= `DGL_RST_VREF;
					pd_reg <= `DGL_RST_PD;
					gain_reg <= `DGL_RST_GAIN;
					nv_vref_reg <= FACTORY_VREF;
					nv_gain_reg <= `DGL_RST_GAIN;
					nv_lock_reg <= `DGL_RST_LOCK;
				end else begin
					// Locked code writes are dropped and flagged on wr_refused
					if (code_hit[c] & ~code_lock) begin
						code_reg <= wr_data[RES_BITS-1:0]; // RULE18
					end
					if (pd_wr) begin
						pd_reg <= wr_data[2*c +: 2]; // RULE6
					end
					// Reset reload outranks any config write in the same cycle
					if (por_load) begin
						vref_reg <= nv_vref_reg; // RULE11
						gain_reg <= nv_gain_reg;
					end else begin
						if (vref_wr & ~cfg_lock) begin
							vref_reg <= wr_data[2*c +: 2]; // RULE18
						end
						if (gain_wr & ~cfg_lock) begin
							gain_reg <= wr_data[`DGL_GAIN_LSB + c]; // RULE18
						end
					end
					if (nv_wr & (wr_addr == `DGL_ADDR_NV_VREF)) begin
						nv_vref_reg <= wr_data[2*c +: 2];
					end
					if (nv_wr & (wr_addr == `DGL_ADDR_NV_GAIN)) begin
						nv_gain_reg <= wr_data[`DGL_GAIN_LSB + c]; // RULE1
					end
					if (nv_wr & (wr_addr == `DGL_ADDR_NV_LOCK)) begin
						nv_lock_reg <= wr_data[2*c +: 2]; // RULE7
					end
				end
			end

			assign code_all[c*RES_BITS +: RES_BITS] = code_reg;
			assign vref_all[2*c +: 2] = vref_reg;
			assign pd_all[2*c +: 2] = pd_reg;
			assign gain_all[c] = gain_reg;
			assign nv_vref_all[2*c +: 2] = nv_vref_reg;
			assign nv_gain_all[c] = nv_gain_reg;
			assign nv_lock_all[2*c +: 2] = nv_lock_reg;

			dgl_chan_route #(
				.RES_BITS(RES_BITS)
			) route_u (
				.ref_clk(ref_clk),
				.reset(reset),
				.vref_sel(vref_reg),
				.gain_bit(gain_reg),
				.pd_field(pd_reg),
				.code(code_reg),
				.ref_route(ref_route[4*c +: 4]),
				.ext_pin_connect(ext_pin_connect[c]),
				.gain_two(gain_two[c]),
				.ladder_tap(ladder_tap[c*RES_BITS +: RES_BITS]),
				.elements_above_tap(elements_above_tap[c*(RES_BITS+1) +: RES_BITS+1]),
				.out_open(out_open[c]),
				.out_load_100k(out_load_100k[c]),
				.out_load_1k(out_load_1k[c])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// Write status
	// --------------------------------------------------------------
	wire known = is_nv | pd_wr | vref_wr | gain_wr | (|code_hit);
	wire refused_now = wr_en & (~known | (is_nv & ~hv_ok) | (|code_blocked) | (|cfg_blocked));

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wr_done <= 1'b0;
			wr_refused <= 1'b0;
		end else begin
			wr_done <= wr_en & ~refused_now;
			wr_refused <= refused_now;
		end
	end

	// --------------------------------------------------------------
	// Read back
	// --------------------------------------------------------------
	reg [15:0] rd_next;

	// Unimplemented bits and unmapped addresses read as zero
	always @* begin
		rd_next = 16'h0000;
		case (rd_addr)
			`DGL_ADDR_CODE0: rd_next[RES_BITS-1:0] = code_all[RES_BITS-1:0];
			`DGL_ADDR_CODE1: begin
				if (NUM_CHAN > 1) begin
					rd_next[RES_BITS-1:0] = code_all[NUM_CHAN*RES_BITS-1 -: RES_BITS];
				end
			end
			`DGL_ADDR_VREF: rd_next[2*NUM_CHAN-1:0] = vref_all;
			`DGL_ADDR_PD: rd_next[2*NUM_CHAN-1:0] = pd_all;
			`DGL_ADDR_GAIN: rd_next[`DGL_GAIN_LSB +: NUM_CHAN] = gain_all;
			`DGL_ADDR_NV_VREF: rd_next[2*NUM_CHAN-1:0] = nv_vref_all;
			`DGL_ADDR_NV_GAIN: rd_next[`DGL_GAIN_LSB +: NUM_CHAN] = nv_gain_all; // RULE1
			`DGL_ADDR_NV_LOCK: rd_next[2*NUM_CHAN-1:0] = nv_lock_all; // RULE7
			default: rd_next = 16'h0000;
		endcase
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= rd_next;
			end
		end
	end

endmodule

/* pkg/dgl_defs.vh */
`ifndef DGL_DEFS_VH
`define DGL_DEFS_VH

// Register addresses of the serial register map
`define DGL_ADDR_CODE0 5'h00
`define DGL_ADDR_CODE1 5'h01
`define DGL_ADDR_VREF 5'h08
`define DGL_ADDR_PD 5'h09
`define DGL_ADDR_GAIN 5'h0A
`define DGL_ADDR_NV_VREF 5'h18
`define DGL_ADDR_NV_GAIN 5'h1A
`define DGL_ADDR_NV_LOCK 5'h1B

// Field positions
`define DGL_GAIN_LSB 8
`define DGL_GAIN_POS_READ 7
`define DGL_LOCK_CODE_BIT 1
`define DGL_LOCK_CFG_BIT 0

// Reference select codes
`define DGL_VREF_SUPPLY 2'h0
`define DGL_VREF_BANDGAP 2'h1
`define DGL_VREF_EXT_UNBUF 2'h2
`define DGL_VREF_EXT_BUF 2'h3

// Power-down codes
`define DGL_PD_NORMAL 2'h0
`define DGL_PD_1K 2'h1
`define DGL_PD_100K 2'h2
`define DGL_PD_OPEN 2'h3

// Reset values
`define DGL_RST_VREF 2'h0
`define DGL_RST_GAIN 1'h0
`define DGL_RST_LOCK 2'h0
`define DGL_RST_PD 2'h0

// Reference route one-hot positions
`define DGL_ROUTE_SUPPLY 0
`define DGL_ROUTE_BANDGAP 1
`define DGL_ROUTE_EXT_UNBUF 2
`define DGL_ROUTE_EXT_BUF 3

`endif

/* core/dgl_chan_route.v */
`timescale 1ns/1ps
`include "dgl_defs.vh"

module dgl_chan_route #(
	parameter RES_BITS = 12
) (
	input wire ref_clk,
	input wire reset,
	input wire [1:0] vref_sel,
	input wire gain_bit,
	input wire [1:0] pd_field,
	input wire [RES_BITS-1:0] code,
	output reg [3:0] ref_route,
	output reg ext_pin_connect,
	output reg gain_two,
	output reg [RES_BITS-1:0] ladder_tap,
	output reg [RES_BITS:0] elements_above_tap,
	output reg out_open,
	output reg out_load_100k,
	output reg out_load_1k
);

	// --------------------------------------------------------------
	// Combinational decode
	// --------------------------------------------------------------
	localparam [RES_BITS:0] ELEMENTS = {1'b1, {RES_BITS{1'b0}}};

	reg [3:0] route_next;
	wire powered = (pd_field == `DGL_PD_NORMAL);

	// Ladder sees its source only while the channel runs
	always @* begin
		route_next = 4'h0;
		case (vref_sel)
			`DGL_VREF_SUPPLY: route_next[`DGL_ROUTE_SUPPLY] = 1'b1; // RULE15
			`DGL_VREF_BANDGAP: route_next[`DGL_ROUTE_BANDGAP] = 1'b1; // RULE15
			`DGL_VREF_EXT_UNBUF: route_next[`DGL_ROUTE_EXT_UNBUF] = 1'b1; // RULE15
			`DGL_VREF_EXT_BUF: route_next[`DGL_ROUTE_EXT_BUF] = 1'b1; // RULE17
			default: route_next = 4'h0;
		endcase
		if (!powered) begin
			route_next = 4'h0; // RULE9
		end
	end

	// --------------------------------------------------------------
	// Registered analog controls
	// --------------------------------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_route <= 4'h0;
			ext_pin_connect <= 1'b0;
			gain_two <= 1'b0;
			ladder_tap <= {RES_BITS{1'b0}};
			elements_above_tap <= ELEMENTS;
			out_open <= 1'b0;
			out_load_100k <= 1'b0;
			out_load_1k <= 1'b0;
		end else begin
			ref_route <= route_next; // RULE10
			// Supply mode keeps the pin off the ladder
			ext_pin_connect <= route_next[`DGL_ROUTE_EXT_UNBUF] | route_next[`DGL_ROUTE_EXT_BUF]; // RULE12
			// Supply reference forces unity gain
			gain_two <= gain_bit & (vref_sel != `DGL_VREF_SUPPLY); // RULE2
			ladder_tap <= code; // RULE8
			elements_above_tap <= ELEMENTS - {1'b0, code}; // RULE8
			out_open <= (pd_field == `DGL_PD_OPEN); // RULE16
			out_load_100k <= (pd_field == `DGL_PD_100K); // RULE16
			out_load_1k <= (pd_field == `DGL_PD_1K); // RULE16
		end
	end

endmodule

/* sim/dgl_control_assertions.sv */
`timescale 1ns/1ps
`include "dgl_defs.vh"
module dgl_control_assertions #(
	parameter NUM_CHAN = 2,
	parameter RES_BITS = 12
) (
	input wire ref_clk,
	input wire reset,
	input wire high_voltage_program_pin,
	input wire wr_en,
	input wire [4:0] wr_addr,
	input wire rd_en,
	input wire [4:0] rd_addr,
	input wire [15:0] rd_data,
	input wire rd_valid,
	input wire wr_done,
	input wire wr_refused,
	input wire [4*NUM_CHAN-1:0] ref_route,
	input wire [NUM_CHAN-1:0] ext_pin_connect,
	input wire [NUM_CHAN-1:0] gain_two,
	input wire [NUM_CHAN*RES_BITS-1:0] ladder_tap,
	input wire [NUM_CHAN*(RES_BITS+1)-1:0] elements_above_tap,
	input wire [NUM_CHAN-1:0] out_open,
	input wire [NUM_CHAN-1:0] out_load_100k,
	input wire [NUM_CHAN-1:0] out_load_1k
);
// ----------------------------------------
// Register port and channel 0 output relations
// ----------------------------------------
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
wire [2:0] pd0 = {out_open[0], out_load_100k[0], out_load_1k[0]};
property p_rd_ans; rd_en |=> rd_valid; endproperty
a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
property p_wr_ans; wr_en |=> wr_done ^ wr_refused; endproperty
a_wr_ans: assert property (p_wr_ans) else $error("write not answered once");
property p_nv_hv; !high_voltage_program_pin [*5] ##1 (wr_en && wr_addr[4:3] == 2'h3) |=> wr_refused; endproperty
a_nv_hv: assert property (p_nv_hv) else $error("nonvolatile write without high voltage");
property p_pd_wr; wr_en && wr_addr == `DGL_ADDR_PD |=> wr_done; endproperty
a_pd_wr: assert property (p_pd_wr) else $error("power-down write refused");
property p_gain_rd; rd_en && rd_addr == `DGL_ADDR_NV_GAIN |=> rd_data[15:10] == 0 && rd_data[7:0] == 0; endproperty
a_gain_rd: assert property (p_gain_rd) else $error("gain register stray bits");
property p_lock_rd; rd_en && rd_addr == `DGL_ADDR_NV_LOCK |=> rd_data[15:4] == 0; endproperty
a_lock_rd: assert property (p_lock_rd) else $error("lock register stray bits");
property p_unity; gain_two[0] |-> !ref_route[`DGL_ROUTE_SUPPLY]; endproperty
a_unity: assert property (p_unity) else $error("gain two on supply reference");
property p_pd_disc; pd0 != 0 |-> ref_route[3:0] == 0; endproperty
a_pd_disc: assert property (p_pd_disc) else $error("ladder connected while powered down");
property p_sup_pin; ref_route[`DGL_ROUTE_SUPPLY] |-> !ext_pin_connect[0]; endproperty
a_sup_pin: assert property (p_sup_pin) else $error("pin on ladder in supply mode");
property p_one_src; $onehot0(ref_route[3:0]) && $onehot0(pd0); endproperty
a_one_src: assert property (p_one_src) else $error("route or load not one-hot");
property p_above; elements_above_tap[RES_BITS:0] == {1'b1, {RES_BITS{1'b0}}} - {1'b0, ladder_tap[RES_BITS-1:0]}; endproperty
a_above: assert property (p_above) else $error("elements above tap wrong");
c_gain: cover property (gain_two[0]);
c_refused: cover property (wr_refused);
c_pd: cover property (pd0 != 0);
endmodule
bind dgl_control dgl_control_assertions #(.NUM_CHAN(NUM_CHAN), .RES_BITS(RES_BITS)) u_chk (.*);

/* sim/dgl_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host on the register port
// ----------------------------------------
module dgl_host_model (
	input wire ref_clk,
	output reg high_voltage_program_pin,
	output reg wr_en,
	output reg [4:0] wr_addr,
	output reg [15:0] wr_data,
	output reg rd_en,
	output reg [4:0] rd_addr,
	input wire [15:0] rd_data,
	input wire wr_done,
	input wire wr_refused
);
// Idle bus shows the inverse of the last value, never a stale copy
initial begin
	high_voltage_program_pin = 1'b0;
	wr_en = 1'b0;
	rd_en = 1'b0;
	wr_addr = 5'h00;
	wr_data = 16'h0000;
	rd_addr = 5'h00;
end
// Programming level held from one call to the next, then six edges for the synchroniser
task set_hv(input v);
	@(posedge ref_clk);
	high_voltage_program_pin <= v;
	repeat (6) @(posedge ref_clk);
endtask
// Reference codes are always written explicitly, supply code when pin tied
task wr(input [4:0] a, input [15:0] d, output [1:0] ans);
	@(posedge ref_clk);
	wr_en <= 1'b1;
	wr_addr <= a;
	wr_data <= d;
	@(posedge ref_clk);
	wr_en <= 1'b0;
	wr_addr <= ~a;
	wr_data <= ~d;
	#1 ans = {wr_done, wr_refused};
endtask
task rd(input [4:0] a, output [15:0] q);
	@(posedge ref_clk);
	rd_en <= 1'b1;
	rd_addr <= a;
	@(posedge ref_clk);
	rd_en <= 1'b0;
	rd_addr <= ~a;
	#1 q = rd_data;
endtask
endmodule

/* sim/dgl_control_bench.sv */
`timescale 1ns/1ps
`include "dgl_defs.vh"
module dgl_control_bench;
reg ref_clk;
reg reset;
reg power_brownout_reset;
wire hv, wr_en, rd_en, rd_valid, wr_done, wr_refused;
wire [4:0] wr_addr, rd_addr;
wire [15:0] wr_data, rd_data;
wire [7:0] ref_route;
wire [1:0] ext_pin_connect, gain_two, out_open, out_load_100k, out_load_1k;
wire [23:0] ladder_tap;
wire [25:0] elements_above_tap;
integer fails, tests_run, cyc, i;
reg [1:0] ans;
reg [15:0] q, ce, ve;
// ----------------------------------------
// Clock, host and device
// ----------------------------------------
initial begin
	ref_clk = 1'b0;
	forever #5 ref_clk = ~ref_clk;
end
dgl_host_model i_host (.ref_clk(ref_clk), .high_voltage_program_pin(hv), .wr_en(wr_en), .wr_addr(wr_addr),
	.wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .wr_done(wr_done), .wr_refused(wr_refused));
dgl_control i_dut (.ref_clk(ref_clk), .reset(reset), .high_voltage_program_pin(hv),
	.power_brownout_reset(power_brownout_reset), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
	.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .wr_done(wr_done),
	.wr_refused(wr_refused), .ref_route(ref_route), .ext_pin_connect(ext_pin_connect), .gain_two(gain_two),
	.ladder_tap(ladder_tap), .elements_above_tap(elements_above_tap), .out_open(out_open),
	.out_load_100k(out_load_100k), .out_load_1k(out_load_1k));
task chk(input [31:0] seen, input [31:0] exp);
	tests_run++;
	if (seen !== exp) begin
		fails++;
		$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask
task final_report;
	$display("tests_run=%0d fails=%0d", tests_run, fails);
	if (fails == 0 && tests_run > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
// Outputs are registered one edge behind the register
task settle;
	repeat (2) @(posedge ref_clk);
	#1;
endtask
task t_nv;
	i_host.wr(`DGL_ADDR_NV_GAIN, 16'hFFFF, ans);
	chk(ans, 2'h1);
	i_host.set_hv(1'b1);
	i_host.wr(`DGL_ADDR_NV_GAIN, 16'hFFFF, ans);
	chk(ans, 2'h2);
	i_host.rd(`DGL_ADDR_NV_GAIN, q);
	chk(q, 16'h0300);
	i_host.wr(`DGL_ADDR_NV_LOCK, 16'hFFFF, ans);
	i_host.rd(`DGL_ADDR_NV_LOCK, q);
	chk(q, 16'h000F);
	$display("test nv done");
endtask
// Lock codes 00..11: code and config writes gated, power-down and NV never
task t_lock;
	ce = 16'h0000;
	ve = 16'h0000;
	for (i = 0; i < 4; i++) begin
		i_host.wr(`DGL_ADDR_NV_LOCK, i, ans);
		i_host.wr(`DGL_ADDR_CODE0, 16'h0100 + i, ans);
		chk(ans, i[1] ? 2'h1 : 2'h2);
		if (!i[1]) ce = 16'h0100 + i;
		i_host.wr(`DGL_ADDR_VREF, i, ans);
		chk(ans, i[0] ? 2'h1 : 2'h2);
		if (!i[0]) ve = i;
		i_host.rd(`DGL_ADDR_CODE0, q);
		chk(q, ce);
		i_host.rd(`DGL_ADDR_VREF, q);
		chk(q, ve);
		i_host.wr(`DGL_ADDR_PD, 16'h0000, ans);
		chk(ans, 2'h2);
		i_host.wr(`DGL_ADDR_NV_GAIN, 16'h0100, ans);
		chk(ans, 2'h2);
	end
	i_host.wr(`DGL_ADDR_NV_LOCK, 16'h0000, ans);
	$display("test lock done");
endtask
task t_route;
	for (i = 0; i < 4; i++) begin
		i_host.wr(`DGL_ADDR_VREF, i, ans);
		i_host.wr(`DGL_ADDR_GAIN, 16'h0100, ans);
		settle;
		chk(ref_route[3:0], 4'h1 << i);
		chk(gain_two[0], i != 0);
		if (i != 1) chk(ext_pin_connect[0], i[1]);
	end
	$display("test route done");
endtask
task t_pd;
	for (i = 1; i < 4; i++) begin
		i_host.wr(`DGL_ADDR_PD, i, ans);
		settle;
		chk(ref_route[3:0], 4'h0);
		chk({out_open[0], out_load_100k[0], out_load_1k[0]}, 3'h1 << (i - 1));
	end
	i_host.wr(`DGL_ADDR_PD, 16'h0000, ans);
	$display("test pd done");
endtask
task t_code;
	i_host.wr(`DGL_ADDR_CODE0, 16'h0FFF, ans);
	settle;
	chk(ladder_tap[11:0], 12'hFFF);
	chk(elements_above_tap[12:0], 13'h0001);
	i_host.wr(`DGL_ADDR_CODE0, 16'h0000, ans);
	settle;
	chk(elements_above_tap[12:0], 13'h1000);
	$display("test code done");
endtask
task t_boot;
	i_host.wr(`DGL_ADDR_NV_VREF, 16'h0001, ans);
	i_host.wr(`DGL_ADDR_VREF, 16'h0003, ans);
	i_host.wr(`DGL_ADDR_GAIN, 16'h0000, ans);
	@(posedge ref_clk);
	power_brownout_reset <= 1'b1;
	repeat (8) @(posedge ref_clk);
	power_brownout_reset <= 1'b0;
	i_host.rd(`DGL_ADDR_VREF, q);
	chk(q, 16'h0001);
	i_host.rd(`DGL_ADDR_GAIN, q);
	chk(q, 16'h0100);
	$display("test boot done");
endtask
// Second channel on its own fields and lock, then a nonvolatile write refused once the pin has been low a while
task t_chan1;
	i_host.wr(`DGL_ADDR_CODE1, 16'h0ABC, ans);
	chk(ans, 2'h2);
	i_host.wr(`DGL_ADDR_VREF, 16'h0004, ans);
	i_host.wr(`DGL_ADDR_GAIN, 16'h0200, ans);
	settle;
	chk(ladder_tap[23:12], 12'hABC);
	chk(ref_route[7:4], 4'h2);
	chk(gain_two[1], 1'b1);
	chk(ext_pin_connect[1], 1'b0);
	i_host.wr(`DGL_ADDR_NV_LOCK, 16'h0008, ans);
	i_host.wr(`DGL_ADDR_CODE1, 16'h0123, ans);
	chk(ans, 2'h1);
	i_host.rd(`DGL_ADDR_CODE1, q);
	chk(q, 16'h0ABC);
	i_host.wr(`DGL_ADDR_CODE0, 16'h0055, ans);
	chk(ans, 2'h2);
	i_host.wr(`DGL_ADDR_NV_LOCK, 16'h0000, ans);
	i_host.set_hv(1'b0);
	i_host.wr(`DGL_ADDR_NV_LOCK, 16'h000F, ans);
	chk(ans, 2'h1);
	i_host.rd(`DGL_ADDR_NV_LOCK, q);
	chk(q, 16'h0000);
	$display("test chan1 done");
endtask
initial begin
	reset = 1'b1;
	power_brownout_reset = 1'b0;
	fails = 0;
	tests_run = 0;
	cyc = 0;
	repeat (20) @(posedge ref_clk);
	reset <= 1'b0;
	repeat (2) @(posedge ref_clk);
	t_nv;
	t_lock;
	t_route;
	t_pd;
	t_code;
	t_boot;
	t_chan1;
	final_report;
end
// Hang guard, well above the under two hundred cycles the tests need
always @(posedge ref_clk) begin
	cyc <= cyc + 1;
	if (cyc == 3000) begin
		fails++;
		final_report;
	end
end
endmodule
